// ===== rtl/icw_identify_words.sv
// identify data words 23..78: read-only word generator for the identify block
// What this block does
// - word 47 reports max sectors per multiple
// - model text 27-46 left aligned, space padded
// - word 49 bit 13 clear, vendor standby
// - word 49 bits 11,10 set for IORDY
// - word 49 bits 9,8 set: LBA, DMA
// - word 50 bit 0 set
// - word 51 upper byte holds 02h
// - word 53 bits 0,1,2 flag valid groups
// - words 57-58 equal cylinders*heads*sectors
// - word 59 valid bit, setting 0 or 1
// - words 60-61 LBA-only sector total
// - word 63 high byte one-hot selected mode
// - word 63 low byte cumulative supported modes
// - timing words supported set word 53 bit 1
// - word 64 bits 0,1 for PIO 3,4
// - word 65 minimum multiword DMA cycle
// - word 66 never below word 65
// - word 67 never below word 68
// - word 68 fastest PIO IORDY cycle
// - unsupported timing words read zero
// - word 69 bit 15, word 75 depth-1
// - words 76 and 78 serial capability flags
module icw_identify_words #(
  parameter int unsigned     MODEL_CHARS   = 40,
  parameter logic [319:0]    MODEL_TEXT    = {"IDENTIFY MODEL", 208'h0},
  parameter logic [63:0]     FW_TEXT       = "REV 0001",
  parameter logic [7:0]      MULT_MAX      = 8'h01,
  parameter logic [2:0]      MDMA_MAX      = 3'h2,
  parameter logic            PIO3_OK       = 1'b1,
  parameter logic            PIO4_OK       = 1'b1,
  parameter logic [15:0]     MDMA_MIN_NS   = icw_pkg::DEF_MDMA_NS,
  parameter logic [15:0]     MDMA_REC_NS   = icw_pkg::DEF_MDMA_NS,
  parameter logic [15:0]     PIO_NOFC_NS   = icw_pkg::DEF_PIO_NOFC_NS,
  parameter logic [15:0]     PIO_IORDY_NS  = icw_pkg::DEF_PIO_IORDY_NS,
  parameter logic [4:0]      NCQ_DEPTH_M1  = icw_pkg::NCQ_DEPTH_M1,
  parameter logic            NCQ_OK        = 1'b1,
  parameter logic            HIPM_OK       = 1'b1,
  parameter logic            EVCNT_OK      = 1'b0,
  parameter logic            GEN2_OK       = 1'b1,
  parameter logic            GEN1_OK       = 1'b1,
  parameter logic [5:0]      SFEAT         = icw_pkg::DEF_SFEAT
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [7:0]       addr,
  input  wire logic [15:0]      wdata,
  input  wire logic             wr_stb,
  input  wire logic             rd_stb,
  output logic      [15:0]      rdata,
  input  wire logic [15:0]      cur_cyl,
  input  wire logic [15:0]      cur_head,
  input  wire logic [15:0]      cur_spt,
  input  wire logic [31:0]      lba_total,
  input  wire logic             mult_set,
  input  wire logic             mdma_sel_vld,
  input  wire icw_pkg::icw_mdma_e mdma_sel,
  input  wire logic             udma_word_vld
);

  // text byte pick: first char lands in the high byte of each word
  function automatic logic [15:0] text_word(input logic [319:0] txt,
                                            input int unsigned  nchar,
                                            input int unsigned  wi);
    logic [7:0]  hi;
    logic [7:0]  lo;
    int unsigned ci;
    ci = 2 * wi;
    hi = txt[319 - 8*ci -: 8];
    lo = txt[319 - 8*(ci+1) -: 8];
    // zero bytes in the string are unused positions: pad with spaces
    if (ci >= nchar || hi == 8'h00) hi = icw_pkg::SPACE_CHAR;
    if (ci + 1 >= nchar || lo == 8'h00) lo = icw_pkg::SPACE_CHAR;
    text_word = {hi, lo};
  endfunction

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  icw_pkg::icw_req_s req;
  icw_pkg::icw_rsp_s rsp;
  logic [15:0]       rdata_q;
  logic [15:0]       rdata_d;
  logic [31:0]       chs_cap_q;
  logic [47:0]       chs_prod;

  assign req.idx = addr;
  assign req.rd  = rd_stb;
  assign req.wr  = wr_stb;

  // product registered: breaks the long multiplier path, one cycle stale
  // after a geometry change, which host reads never observe in practice
  assign chs_prod = cur_cyl * cur_head * cur_spt;

  wire logic        timing_any   = (MDMA_MAX != 3'h0) || PIO3_OK || PIO4_OK;
  wire logic        pio3_up      = PIO3_OK || PIO4_OK;
  wire logic [15:0] w47 = {8'h00, MULT_MAX};
  wire logic [15:0] w49 = (16'h0001 << icw_pkg::B49_IORDY)
                        | (16'h0001 << icw_pkg::B49_IORDY_DIS)
                        | (16'h0001 << icw_pkg::B49_LBA)
                        | (16'h0001 << icw_pkg::B49_DMA)
                        & ~(16'h0001 << icw_pkg::B49_STBY);
  wire logic [15:0] w50 = 16'h0001 << icw_pkg::B50_STBY_VS;
  wire logic [15:0] w51 = {icw_pkg::PIO_LEGACY_MODE, 8'h00};
  wire logic [15:0] w53 = (16'h0001 << icw_pkg::B53_CHS)
                        | ({15'h0000, timing_any} << icw_pkg::B53_TIMING)
                        | ({15'h0000, udma_word_vld}
                           << icw_pkg::B53_UDMA);
  wire logic [7:0]  mult_cur = mult_set ? icw_pkg::MULT_SET_MAX : 8'h00;
  wire logic [15:0] w59 = (16'h0001 << icw_pkg::B59_VALID)
                        | {8'h00, mult_cur};
  // one-hot selected mode; nothing selected when mdma_sel_vld is low
  wire logic [7:0]  mdma_hi = mdma_sel_vld
                        ? (8'h01 << mdma_sel) : 8'h00;
  // mode n supported means bits n..0 all set, hence the shift by n+1
  wire logic [7:0]  mdma_lo = (MDMA_MAX == 3'h0) ? 8'h00
                        : ~(8'hFF << ({1'b0, MDMA_MAX} + 4'h1));
  wire logic [15:0] w63 = {mdma_hi, mdma_lo};
  wire logic [15:0] w64 = {14'h0000, PIO4_OK, PIO3_OK};
  wire logic        mdma_sup = MDMA_MAX != 3'h0;
  wire logic [15:0] w65 = mdma_sup ? MDMA_MIN_NS : icw_pkg::ZERO_WORD;
  // clamp keeps the recommended figure at or above the minimum
  wire logic [15:0] rec_ns = (MDMA_REC_NS < MDMA_MIN_NS)
                        ? MDMA_MIN_NS : MDMA_REC_NS;
  wire logic [15:0] w66 = mdma_sup ? rec_ns : icw_pkg::ZERO_WORD;
  wire logic [15:0] w68 = pio3_up ? PIO_IORDY_NS : icw_pkg::ZERO_WORD;
  wire logic [15:0] nofc = (PIO_NOFC_NS < PIO_IORDY_NS)
                        ? PIO_IORDY_NS : PIO_NOFC_NS;
  wire logic [15:0] w67 = pio3_up ? nofc : icw_pkg::ZERO_WORD;
  wire logic [15:0] w69 = 16'h0001 << icw_pkg::B69_SPEC;
  wire logic [15:0] w75 = {11'h000, NCQ_DEPTH_M1};
  wire logic [15:0] w76 = ({15'h0000, EVCNT_OK} << icw_pkg::B76_EVCNT)
                        | ({15'h0000, HIPM_OK} << icw_pkg::B76_HIPM)
                        | ({15'h0000, NCQ_OK} << icw_pkg::B76_NCQ)
                        | ({15'h0000, GEN2_OK} << icw_pkg::B76_GEN2)
                        | ({15'h0000, GEN1_OK}
                           << icw_pkg::B76_GEN1);
  wire logic [15:0] w78 = {9'h000, SFEAT, 1'b0};

  wire logic [7:0]  fw_off    = addr - icw_pkg::W_FW_FIRST;
  wire logic [7:0]  model_off = addr - icw_pkg::W_MODEL_FIRST;
  wire logic [319:0] fw_pad   = {FW_TEXT, 256'h0};

  always_comb begin
    rdata_d = icw_pkg::ZERO_WORD;
    rsp.hit = 1'b1;
    if (in_range(addr, icw_pkg::W_FW_FIRST, icw_pkg::W_FW_LAST)) begin
      rdata_d = text_word(fw_pad, 8, int'(fw_off));
    end else if (in_range(addr, icw_pkg::W_MODEL_FIRST,
                          icw_pkg::W_MODEL_LAST)) begin
      rdata_d = text_word(MODEL_TEXT, MODEL_CHARS, int'(model_off));
    end else begin
      unique case (addr)
        icw_pkg::W_MULT_MAX:  rdata_d = w47;
        icw_pkg::W_CAP49:     rdata_d = w49;
        icw_pkg::W_CAP50:     rdata_d = w50;
        icw_pkg::W_PIO51:     rdata_d = w51;
        icw_pkg::W_VALID53:   rdata_d = w53;
        icw_pkg::W_CYL:       rdata_d = cur_cyl;
        icw_pkg::W_HEAD:      rdata_d = cur_head;
        icw_pkg::W_SPT:       rdata_d = cur_spt;
        icw_pkg::W_CAPA_LO:   rdata_d = chs_cap_q[15:0];
        icw_pkg::W_CAPA_HI:   rdata_d = chs_cap_q[31:16];
        icw_pkg::W_MULT_SET:  rdata_d = w59;
        icw_pkg::W_LBA_LO:    rdata_d = lba_total[15:0];
        icw_pkg::W_LBA_HI:    rdata_d = lba_total[31:16];
        icw_pkg::W_MDMA:      rdata_d = w63;
        icw_pkg::W_APIO:      rdata_d = w64;
        icw_pkg::W_MDMA_MIN:  rdata_d = w65;
        icw_pkg::W_MDMA_REC:  rdata_d = w66;
        icw_pkg::W_PIO_NOFC:  rdata_d = w67;
        icw_pkg::W_PIO_IORDY: rdata_d = w68;
        icw_pkg::W_SPEC69:    rdata_d = w69;
        icw_pkg::W_NCQ:       rdata_d = w75;
        icw_pkg::W_SCAP76:    rdata_d = w76;
        icw_pkg::W_SFEAT78:   rdata_d = w78;
        default: begin
          // reserved and out-of-range words read zero
          rdata_d = icw_pkg::ZERO_WORD;
          rsp.hit = 1'b0;
        end
      endcase
    end
    rsp.data = rdata_d;
  end

  // writes never reach any state: every word is generated
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q   <= icw_pkg::ZERO_WORD;
      chs_cap_q <= 32'h0000_0000;
    end else begin
      chs_cap_q <= chs_prod[31:0];
      if (req.rd) begin
        rdata_q <= rsp.data;
      end else begin
        rdata_q <= icw_pkg::ZERO_WORD;
      end
    end
  end

  assign rdata = rdata_q;

  wire logic unused_ok = &{1'b0, wdata, req.wr, rsp.hit};

endmodule

// ===== rtl/icw_pkg.sv
// package: word indices, field positions and defaults of the identify words
package icw_pkg;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam logic [7:0] W_FW_FIRST = 8'h17;
  localparam logic [7:0] W_FW_LAST = 8'h1A;
  localparam logic [7:0] W_MODEL_FIRST = 8'h1B;
  localparam logic [7:0] W_MODEL_LAST = 8'h2E;
  localparam logic [7:0] W_MULT_MAX = 8'h2F;
  localparam logic [7:0] W_CAP49 = 8'h31;
  localparam logic [7:0] W_CAP50 = 8'h32;
  localparam logic [7:0] W_PIO51 = 8'h33;
  localparam logic [7:0] W_VALID53 = 8'h35;
  localparam logic [7:0] W_CYL = 8'h36;
  localparam logic [7:0] W_HEAD = 8'h37;
  localparam logic [7:0] W_SPT = 8'h38;
  localparam logic [7:0] W_CAPA_LO = 8'h39;
  localparam logic [7:0] W_CAPA_HI = 8'h3A;
  localparam logic [7:0] W_MULT_SET = 8'h3B;
  localparam logic [7:0] W_LBA_LO = 8'h3C;
  localparam logic [7:0] W_LBA_HI = 8'h3D;
  localparam logic [7:0] W_MDMA = 8'h3F;
  localparam logic [7:0] W_APIO = 8'h40;
  localparam logic [7:0] W_MDMA_MIN = 8'h41;
  localparam logic [7:0] W_MDMA_REC = 8'h42;
  localparam logic [7:0] W_PIO_NOFC = 8'h43;
  localparam logic [7:0] W_PIO_IORDY = 8'h44;
  localparam logic [7:0] W_SPEC69 = 8'h45;
  localparam logic [7:0] W_NCQ = 8'h4B;
  localparam logic [7:0] W_SCAP76 = 8'h4C;
  localparam logic [7:0] W_SFEAT78 = 8'h4E;
  // field positions
  localparam int unsigned B49_STBY = 13;
  localparam int unsigned B49_IORDY = 11;
  localparam int unsigned B49_IORDY_DIS = 10;
  localparam int unsigned B49_LBA = 9;
  localparam int unsigned B49_DMA = 8;
  localparam int unsigned B50_STBY_VS = 0;
  localparam int unsigned B53_CHS = 0;
  localparam int unsigned B53_TIMING = 1;
  localparam int unsigned B53_UDMA = 2;
  localparam int unsigned B59_VALID = 8;
  localparam int unsigned B69_SPEC = 15;
  localparam int unsigned B76_EVCNT = 10;
  localparam int unsigned B76_HIPM = 9;
  localparam int unsigned B76_NCQ = 8;
  localparam int unsigned B76_GEN2 = 2;
  localparam int unsigned B76_GEN1 = 1;
  localparam logic [7:0] PIO_LEGACY_MODE = 8'h02;
  localparam logic [7:0] SPACE_CHAR = 8'h20;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] MULT_SET_MAX = 8'h01;
  localparam logic [4:0] NCQ_DEPTH_M1 = 5'h1F;
  localparam logic [15:0] DEF_PIO_IORDY_NS = 16'h0078;
  localparam logic [15:0] DEF_PIO_NOFC_NS = 16'h0078;
  localparam logic [15:0] DEF_MDMA_NS = 16'h0078;
  localparam logic [5:0] DEF_SFEAT = 6'h00;

  // read port carrier
  typedef struct packed {
    logic [7:0]  idx;
    logic        rd;
    logic        wr;
  } icw_req_s;

  typedef struct packed {
    logic [15:0] data;
    logic        hit;
  } icw_rsp_s;

  typedef enum logic [1:0] {
    ICW_MDMA_M0,
    ICW_MDMA_M1,
    ICW_MDMA_M2
  } icw_mdma_e;
endpackage

// ===== verif/icw_host_model.sv
// host side: reads a range of identify words in order, writes between when slow is set
module icw_host_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [7:0]  first,
  input  wire logic [7:0]  last,
  output logic      [7:0]  addr = 8'h00,
  output logic      [15:0] wdata = 16'h0000,
  output logic             wr_stb = 1'b0,
  output logic             rd_stb = 1'b0,
  output logic             busy = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] nxt = 8'h00;
  logic       gap = 1'b0;
  always @(posedge ref_clk) begin
    // idle lines toggle so a stale value never looks valid
    addr <= ~addr;
    wdata <= ~wdata;
    rd_stb <= 1'b0;
    wr_stb <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      nxt <= first;
      gap <= 1'b0;
    end else if (busy && gap) begin
      gap <= 1'b0;
      wr_stb <= 1'b1;
      addr <= nxt;
      wdata <= 16'($urandom);
    end else if (busy) begin
      rd_stb <= 1'b1;
      addr <= nxt;
      nxt <= nxt + 8'h01;
      gap <= slow;
      busy <= (nxt != last);
    end
  end
endmodule

// ===== verif/icw_monitor.sv
// concurrent checks on the identify word read port
module icw_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  input wire logic        mult_set,
  input wire logic        udma_word_vld
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [7:0] w);
    rd_stb && addr == w;
  endsequence
  property p_cap49;
    s_rd(icw_pkg::W_CAP49) |=> rdata == 16'h0f00;
  endproperty
  a_cap49: assert property (p_cap49)
    else $error("word 49 flags wrong");
  property p_cap50;
    s_rd(icw_pkg::W_CAP50) |=> rdata == 16'h0001;
  endproperty
  a_cap50: assert property (p_cap50)
    else $error("word 50 wrong");
  property p_pio51;
    s_rd(icw_pkg::W_PIO51) |=> rdata == 16'h0200;
  endproperty
  a_pio51: assert property (p_pio51)
    else $error("word 51 wrong");
  property p_valid53;
    s_rd(icw_pkg::W_VALID53) |=>
      rdata == {13'h0000, $past(udma_word_vld), 2'b11};
  endproperty
  a_valid53: assert property (p_valid53)
    else $error("word 53 wrong");
  property p_mult59;
    s_rd(icw_pkg::W_MULT_SET) |=> rdata == {8'h01, 7'h00, $past(mult_set)};
  endproperty
  a_mult59: assert property (p_mult59)
    else $error("word 59 wrong");
  property p_mdma63;
    s_rd(icw_pkg::W_MDMA) |=>
      $onehot0(rdata[15:8]) && rdata[15:11] == 5'h00 && rdata[7:0] == 8'h07;
  endproperty
  a_mdma63: assert property (p_mdma63)
    else $error("word 63 wrong");
  property p_ncq75;
    s_rd(icw_pkg::W_NCQ) |=> rdata[15:5] == 11'h000;
  endproperty
  a_ncq75: assert property (p_ncq75)
    else $error("word 75 reserved bits set");
  property p_scap76;
    s_rd(icw_pkg::W_SCAP76) |=> !rdata[0] && rdata[15:11] == 5'h00;
  endproperty
  a_scap76: assert property (p_scap76)
    else $error("word 76 reserved bits set");
  property p_wr_quiet;
    wr_stb |=> rdata == 16'h0000 ##1 ($past(rd_stb) || rdata == 16'h0000);
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("write disturbed read data");
  c_mdma2: cover property (s_rd(icw_pkg::W_MDMA) ##1 rdata[10]);
  c_wr_rd: cover property (wr_stb ##1 rd_stb);
  c_b2b: cover property (rd_stb ##1 rd_stb);
endmodule
bind icw_identify_words icw_monitor i_mon (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .mult_set(mult_set),
  .udma_word_vld(udma_word_vld));

// ===== verif/identify_capability_words_tb.sv
// self-checking bench for the identify word generator
module identify_capability_words_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // odd length puts a pad byte inside a word
  localparam logic [319:0] MODEL = {"BENCH DRIVE 7", 216'h0};
  localparam logic [63:0]  FW    = "FW 1.2.3";
  logic ref_clk = 1'b0, rst = 1'b1, go = 1'b0, slow = 1'b0;
  logic [7:0]  first = 8'h00, last = 8'h00, addr;
  logic [15:0] cyl = 16'h0001, head = 16'h0001, spt = 16'h0001;
  logic [15:0] wdata, rdata;
  logic [31:0] lba = 32'h0000_0000;
  logic mult = 1'b0, mvld = 1'b0, udma = 1'b0, wr_stb, rd_stb, busy;
  logic pend = 1'b0;
  icw_pkg::icw_mdma_e sel = icw_pkg::ICW_MDMA_M0;
  logic [15:0] q[$];
  int failures = 0, tests_run = 0;
  icw_host_model i_host (.ref_clk(ref_clk), .rst(rst), .go(go),
    .slow(slow), .first(first), .last(last), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .busy(busy));
  icw_identify_words #(.MODEL_TEXT(MODEL), .FW_TEXT(FW)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cur_cyl(cyl),
    .cur_head(head), .cur_spt(spt), .lba_total(lba), .mult_set(mult),
    .mdma_sel_vld(mvld), .mdma_sel(sel), .udma_word_vld(udma));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] chr(input int k);
    chr = MODEL[319-8*k -: 8] == 8'h00 ? 8'h20 : MODEL[319-8*k -: 8];
  endfunction
  function automatic logic [15:0] exp_word(input logic [7:0] i);
    logic [31:0] cap;
    cap = cyl * head * spt;
    if (i >= icw_pkg::W_FW_FIRST && i <= icw_pkg::W_FW_LAST)
      return FW[63-16*(i-23) -: 16];
    if (i >= icw_pkg::W_MODEL_FIRST && i <= icw_pkg::W_MODEL_LAST)
      return {chr(2*(i-27)), chr(2*(i-27)+1)};
    case (i)
      icw_pkg::W_MULT_MAX:  return 16'h0001;
      icw_pkg::W_CAP49:     return 16'h0f00;
      icw_pkg::W_CAP50:     return 16'h0001;
      icw_pkg::W_PIO51:     return 16'h0200;
      icw_pkg::W_VALID53:   return {13'h0000, udma, 2'b11};
      icw_pkg::W_CYL:       return cyl;
      icw_pkg::W_HEAD:      return head;
      icw_pkg::W_SPT:       return spt;
      icw_pkg::W_CAPA_LO:   return cap[15:0];
      icw_pkg::W_CAPA_HI:   return cap[31:16];
      icw_pkg::W_MULT_SET:  return {8'h01, 7'h00, mult};
      icw_pkg::W_LBA_LO:    return lba[15:0];
      icw_pkg::W_LBA_HI:    return lba[31:16];
      icw_pkg::W_MDMA:      return {8'(mvld) << sel, 8'h07};
      icw_pkg::W_APIO:      return 16'h0003;
      icw_pkg::W_MDMA_MIN, icw_pkg::W_MDMA_REC, icw_pkg::W_PIO_NOFC,
      icw_pkg::W_PIO_IORDY: return 16'h0078;
      icw_pkg::W_SPEC69:    return 16'h8000;
      icw_pkg::W_NCQ:       return 16'h001f;
      icw_pkg::W_SCAP76:    return 16'h0306;
      default:              return 16'h0000;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected rdata expected %h seen %h", exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(negedge ref_clk) begin
    if (pend) check(rdata, q.pop_front());
    else if (!rst) check(rdata, 16'h0000);
    pend = rd_stb;
    if (rd_stb) q.push_back(exp_word(addr));
  end
  task automatic sweep(input logic [7:0] f, l, input logic s);
    int n;
    @(posedge ref_clk);
    first <= f;
    last <= l;
    slow <= s;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(negedge ref_clk);
    for (n = 0; busy !== 1'b0 && n < 600; n++) @(negedge ref_clk);
    if (n == 600) begin
      failures++;
      wrap_up();
    end
    repeat (3) @(posedge ref_clk);
  endtask
  initial begin
    void'($urandom(32'hcdf4));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    sweep(8'h00, 8'hff, 1'b0);
    for (int j = 0; j < 4; j++) begin
      @(posedge ref_clk);
      cyl <= 16'($urandom);
      head <= 16'($urandom_range(16, 1));
      spt <= 16'($urandom_range(255, 1));
      lba <= $urandom;
      mult <= 1'($urandom_range(1, 0));
      udma <= j[0];
      mvld <= (j < 3);
      sel <= icw_pkg::icw_mdma_e'(j % 3);
      repeat (4) @(posedge ref_clk);
      sweep(8'h2f, 8'h4e, 1'b1);
    end
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    sweep(8'h31, 8'h3b, 1'b0);
    wrap_up();
  end
endmodule
